// *** src/hsp_regs.sv ***
// Host semaphore and pending-clear register bank, top level.
// Assumes a single-cycle register port master and same-clock control inputs.
//
// Summary of operation
// [R1] First semaphore read returns 0, later reads 1
// [R2] Driver semaphore holds until driver writes 0
// [R3] Reading semaphore register sets bit 0
// [R4] Memory semaphore set by driver, firmware reads
// [R5] Host soft reset clears memory semaphore
// [R6] Driver should prefer config-control ownership bit instead
// [R7] Driver writes 1 to control-two bit 0
// [R8] Writing 1 clears matching pending bit
// [R9] Auto clear pending bit on request deassert
// [R10] Reserved bits read zero, writes ignored
`include "hsp_defs.svh"
`default_nettype none

module hsp_regs #(
  parameter int PEND_W = `HSP_PEND_W
) (
  input  wire logic                 mclk_i,          // Core clock, 25 MHz
  input  wire logic                 rst_n_i,         // Async reset, active low
  input  wire hsp_pkg::hsp_bus_req_s bus_i,          // Register port request
  output logic [`HSP_DW-1:0]        rdata_o,         // Read data, cycle after read
  input  wire logic                 soft_rst_i,      // Host interface soft reset pulse
  input  wire logic                 pend_clr_deas_i, // Pending clear on deassert control
  input  wire logic [PEND_W-1:0]    pend_set_i,      // Pending set pulses
  input  wire logic [PEND_W-1:0]    irq_req_i,       // Interrupt request levels
  output logic [PEND_W-1:0]         pending_o,       // Interrupt pending array
  output logic                      drv_sem_o,       // Driver semaphore flag
  output logic                      mem_sem_o,       // Memory semaphore, read-only to firmware
  output logic                      init_done_o,     // Control-two initialisation bit
  output logic [`HSP_DW-1:0]        stat3_o          // Statistic counter three contents
);

  // ******************************************
  // Parameter check
  // ******************************************
  if (PEND_W < 1 || PEND_W > `HSP_DW) begin : g_chk
    $error("PEND_W out of range");
  end

  // ******************************************
  // Address decode
  // ******************************************
  function automatic logic hit(input hsp_pkg::hsp_addr_t a, input hsp_pkg::hsp_addr_t off);
    hit = (a == off);
  endfunction

  logic wr_sem;
  logic rd_sem;
  logic wr_ctl2;
  logic rd_ctl2;
  logic wr_stat3;
  logic rd_stat3;
  logic wr_pba;

  assign wr_sem   = bus_i.wr && hit(bus_i.addr, `HSP_OFF_SEM);
  assign rd_sem   = bus_i.rd && hit(bus_i.addr, `HSP_OFF_SEM);
  assign wr_ctl2  = bus_i.wr && hit(bus_i.addr, `HSP_OFF_CTL2);
  assign rd_ctl2  = bus_i.rd && hit(bus_i.addr, `HSP_OFF_CTL2);
  assign wr_stat3 = bus_i.wr && hit(bus_i.addr, `HSP_OFF_STAT3);
  assign rd_stat3 = bus_i.rd && hit(bus_i.addr, `HSP_OFF_STAT3);
  assign wr_pba   = bus_i.wr && hit(bus_i.addr, `HSP_OFF_PENDING_ARRAY_CLEAR);

  // ******************************************
  // Driver semaphore
  // ******************************************
  logic drv_sem_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drv_sem_q <= 1'b0;
    end else if (rd_sem) begin
      drv_sem_q <= 1'b1;                                     // R1 R3
    end else if (wr_sem && !bus_i.wdata[`HSP_SEM_DRV_BIT]) begin
      drv_sem_q <= 1'b0;                                     // R2
    end
  end

  // ******************************************
  // Memory-access semaphore
  // ******************************************
  logic mem_sem_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_sem_q <= 1'b0;
    end else if (soft_rst_i) begin
      mem_sem_q <= 1'b0;                                     // R5
    end else if (wr_sem) begin
      mem_sem_q <= bus_i.wdata[`HSP_SEM_MEM_BIT];            // R4
    end
  end

  // ******************************************
  // Control two and statistic counter three
  // ******************************************
  logic             init_q;
  logic [`HSP_DW-1:0] stat3_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_q <= 1'b0;
    end else if (wr_ctl2) begin
      init_q <= bus_i.wdata[`HSP_CTL2_INIT_BIT];             // R7 R10
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat3_q <= `HSP_STAT3_RST;
    end else if (wr_stat3) begin
      stat3_q <= bus_i.wdata;
    end
  end

  // ******************************************
  // Pending array
  // ******************************************
  logic [PEND_W-1:0] pba_clr;

  assign pba_clr = wr_pba ? bus_i.wdata[PEND_W-1:0] : '0;    // R8

  hsp_pend_array #(
    .PEND_W     (PEND_W)
  ) u_pend (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .set_i      (pend_set_i),
    .clr_i      (pba_clr),
    .auto_dis_i (pend_clr_deas_i),                            // R9
    .req_i      (irq_req_i),
    .pending_o  (pending_o)
  );

  // ******************************************
  // Read data
  // ******************************************
  logic [`HSP_DW-1:0] rdata_d;
  logic [`HSP_DW-1:0] rdata_q;

  always_comb begin
    rdata_d = `HSP_RDATA_IDLE;                               // R10
    if (rd_sem) begin
      rdata_d[`HSP_SEM_DRV_BIT] = drv_sem_q;                 // R1
      rdata_d[`HSP_SEM_MEM_BIT] = mem_sem_q;
    end else if (rd_ctl2) begin
      rdata_d[`HSP_CTL2_INIT_BIT] = init_q;
    end else if (rd_stat3) begin
      rdata_d = stat3_q;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= `HSP_RDATA_IDLE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o     = rdata_q;
  assign drv_sem_o   = drv_sem_q;
  assign mem_sem_o   = mem_sem_q;
  assign init_done_o = init_q;
  assign stat3_o     = stat3_q;

  // ******************************************
  // Assertions
  // ******************************************
  property p_sem_first_read;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (rd_sem && !drv_sem_q) |=> (rdata_o[`HSP_SEM_DRV_BIT] == 1'b0) && drv_sem_o;
  endproperty
  a_sem_first_read: assert property (p_sem_first_read) else $error("first semaphore read wrong"); // R1

  property p_sem_second_read;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rd_sem ##1 (rd_sem && !wr_sem) |=> rdata_o[`HSP_SEM_DRV_BIT];
  endproperty
  a_sem_second_read: assert property (p_sem_second_read) else $error("second read not 1"); // R3

  property p_sem_hold;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (drv_sem_o && !(wr_sem && !bus_i.wdata[`HSP_SEM_DRV_BIT])) |=> drv_sem_o;
  endproperty
  a_sem_hold: assert property (p_sem_hold) else $error("semaphore dropped"); // R2

  property p_sem_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (wr_sem && !bus_i.wdata[`HSP_SEM_DRV_BIT]) |=> !drv_sem_o;
  endproperty
  a_sem_clear: assert property (p_sem_clear) else $error("semaphore not cleared"); // R2

  property p_mem_soft_rst;
    @(posedge mclk_i) disable iff (!rst_n_i)
      soft_rst_i |=> !mem_sem_o;
  endproperty
  a_mem_soft_rst: assert property (p_mem_soft_rst) else $error("soft reset kept memory semaphore"); // R5

  property p_mem_only_drv;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(mem_sem_o) |-> $past(wr_sem) && $past(bus_i.wdata[`HSP_SEM_MEM_BIT]) && !$past(soft_rst_i);
  endproperty
  a_mem_only_drv: assert property (p_mem_only_drv) else $error("memory semaphore set without write"); // R4

  property p_pba_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      wr_pba |=> ((pending_o & $past(pba_clr) & ~$past(pend_set_i)) == '0);
  endproperty
  a_pba_clear: assert property (p_pba_clear) else $error("pending bit not cleared"); // R8

  property p_pba_keep;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (wr_pba && pending_o[0] && !bus_i.wdata[0]
        && (pend_clr_deas_i || irq_req_i[0] || !$past(irq_req_i[0]))) |=> pending_o[0];
  endproperty
  a_pba_keep: assert property (p_pba_keep) else $error("pending bit lost on zero write"); // R8

  property p_auto_clear;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (!pend_clr_deas_i && $fell(irq_req_i[0]) && !pend_set_i[0]) |=> !pending_o[0];
  endproperty
  a_auto_clear: assert property (p_auto_clear) else $error("no clear on deassert"); // R9

  property p_sem_rsv;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rd_sem |=> (rdata_o[`HSP_DW-1:2] == '0);
  endproperty
  a_sem_rsv: assert property (p_sem_rsv) else $error("semaphore reserved bits nonzero"); // R10

  property p_ctl2_read;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (wr_ctl2 && bus_i.wdata[0]) ##1 rd_ctl2 |=> (rdata_o == 32'h0000_0001);
  endproperty
  a_ctl2_read: assert property (p_ctl2_read) else $error("control two readback wrong"); // R7 R10

  property p_idle_rdata;
    @(posedge mclk_i) disable iff (!rst_n_i)
      !bus_i.rd |=> (rdata_o == '0);
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data outside read slot"); // R10

  property p_sem_read_old;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rd_sem |=> (rdata_o[`HSP_SEM_DRV_BIT] == $past(drv_sem_o));
  endproperty
  a_sem_read_old: assert property (p_sem_read_old) else $error("semaphore read not old value"); // R1

  property p_sem_rd_sets;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rd_sem |=> drv_sem_o;
  endproperty
  a_sem_rd_sets: assert property (p_sem_rd_sets) else $error("semaphore read did not set flag"); // R3

  property p_sem_set_cause;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $rose(drv_sem_o) |-> $past(rd_sem);
  endproperty
  a_sem_set_cause: assert property (p_sem_set_cause) else $error("semaphore set without read"); // R3

  property p_mem_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (wr_sem && !soft_rst_i) |=> (mem_sem_o == $past(bus_i.wdata[`HSP_SEM_MEM_BIT]));
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("memory semaphore write lost"); // R4

  property p_mem_read;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rd_sem |=> (rdata_o[`HSP_SEM_MEM_BIT] == $past(mem_sem_o));
  endproperty
  a_mem_read: assert property (p_mem_read) else $error("memory semaphore readback wrong"); // R4

  property p_init_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
      wr_ctl2 |=> (init_done_o == $past(bus_i.wdata[`HSP_CTL2_INIT_BIT]));
  endproperty
  a_init_write: assert property (p_init_write) else $error("control two bit not stored"); // R7 R10

  property p_ctl2_rsv;
    @(posedge mclk_i) disable iff (!rst_n_i)
      rd_ctl2 |=> (rdata_o[`HSP_DW-1:1] == '0);
  endproperty
  a_ctl2_rsv: assert property (p_ctl2_rsv) else $error("control two reserved bits nonzero"); // R10

  property p_pba_read_zero;
    @(posedge mclk_i) disable iff (!rst_n_i)
      (bus_i.rd && (bus_i.addr == `HSP_OFF_PENDING_ARRAY_CLEAR)) |=> (rdata_o == '0);
  endproperty
  a_pba_read_zero: assert property (p_pba_read_zero) else $error("pending clear read nonzero"); // R10

  property p_pba_set_wins;
    @(posedge mclk_i) disable iff (!rst_n_i)
      pend_set_i[0] |=> pending_o[0];
  endproperty
  a_pba_set_wins: assert property (p_pba_set_wins) else $error("pending set lost"); // R8

  property p_pba_fall_cause;
    @(posedge mclk_i) disable iff (!rst_n_i)
      $fell(pending_o[0]) |-> ($past(pba_clr[0])
        || (!$past(pend_clr_deas_i) && !$past(irq_req_i[0]) && $past(irq_req_i[0], 2)));
  endproperty
  a_pba_fall_cause: assert property (p_pba_fall_cause) else $error("pending bit cleared without cause"); // R8 R9

endmodule

`default_nettype wire

// *** src/hsp_defs.svh ***
// Offsets, field positions, reset values and widths of the host semaphore bank.
// Assumes byte addresses on the register port; each register takes one 32-bit word.
`ifndef HSP_DEFS_SVH
`define HSP_DEFS_SVH

`define HSP_AW              20
`define HSP_DW              32
`define HSP_OFF_STAT3       20'h05B2C
`define HSP_OFF_SEM         20'h05B50
`define HSP_OFF_CTL2        20'h05B64
`define HSP_OFF_PENDING_ARRAY_CLEAR      20'h05B68
`define HSP_SEM_DRV_BIT     0
`define HSP_SEM_MEM_BIT     1
`define HSP_CTL2_INIT_BIT   0
`define HSP_PEND_W          5
`define HSP_STAT3_RST       32'h0000_0000
`define HSP_RDATA_IDLE      32'h0000_0000

`endif

// *** src/hsp_pkg.sv ***
// Types shared by the host semaphore bank.
// Assumes hsp_defs.svh is on the include path.
`include "hsp_defs.svh"
`default_nettype none

package hsp_pkg;

  typedef logic [`HSP_AW-1:0] hsp_addr_t;
  typedef logic [`HSP_DW-1:0] hsp_data_t;

  // One register-port access as driven by software
  typedef struct packed {
    hsp_addr_t addr;
    hsp_data_t wdata;
    logic      wr;
    logic      rd;
  } hsp_bus_req_s;

endpackage

`default_nettype wire

// *** src/hsp_pend_array.sv ***
// Interrupt pending array: per-vector sticky bits with explicit and automatic clear.
// Assumes all inputs come from logic on mclk_i.
`include "hsp_defs.svh"
`default_nettype none

module hsp_pend_array #(
  parameter int PEND_W = `HSP_PEND_W
) (
  input  wire logic              mclk_i,        // Core clock
  input  wire logic              rst_n_i,       // Async reset, active low
  input  wire logic [PEND_W-1:0] set_i,         // Pending set pulses
  input  wire logic [PEND_W-1:0] clr_i,         // Software clear mask pulse
  input  wire logic              auto_dis_i,    // High disables clear on deassert
  input  wire logic [PEND_W-1:0] req_i,         // Interrupt request levels
  output logic      [PEND_W-1:0] pending_o      // Pending array
);

  if (PEND_W < 1) begin : g_chk
    $error("PEND_W out of range");
  end

  logic [PEND_W-1:0] req_q;
  logic [PEND_W-1:0] pend_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q <= '0;
    end else begin
      req_q <= req_i;
    end
  end

  // ******************************************
  // Per-bit pending state, set wins over clear
  // ******************************************
  for (genvar g = 0; g < PEND_W; g++) begin : g_bit
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        pend_q[g] <= 1'b0;
      end else if (set_i[g]) begin
        pend_q[g] <= 1'b1;
      end else if (clr_i[g]) begin
        pend_q[g] <= 1'b0;                                   // R8
      end else if (!auto_dis_i && req_q[g] && !req_i[g]) begin
        pend_q[g] <= 1'b0;                                   // R9
      end
    end
  end

  assign pending_o = pend_q;

endmodule

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the host semaphore and pending-clear register bank.
// Assumes hsp_defs.svh on the include path and hsp_pkg compiled before this file.
`include "hsp_defs.svh"
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals and design instance
  // ****************************************************************
  logic                     mclk_i;
  logic                     rst_n_i;
  hsp_pkg::hsp_bus_req_s    bus;
  logic [`HSP_DW-1:0]       rdata_o;
  logic                     soft_rst_i;
  logic                     pend_clr_deas_i;
  logic [`HSP_PEND_W-1:0]   pend_set_i;
  logic [`HSP_PEND_W-1:0]   irq_req_i;
  logic [`HSP_PEND_W-1:0]   pending_o;
  logic                     drv_sem_o;
  logic                     mem_sem_o;
  logic                     init_done_o;
  logic [`HSP_DW-1:0]       stat3_o;
  int                       miscompares;
  int                       num_checks;
  logic                     prev_rd;
  hsp_pkg::hsp_data_t       prev_exp;

  hsp_regs u_dut (
    .mclk_i          (mclk_i),
    .rst_n_i         (rst_n_i),
    .bus_i           (bus),
    .rdata_o         (rdata_o),
    .soft_rst_i      (soft_rst_i),
    .pend_clr_deas_i (pend_clr_deas_i),
    .pend_set_i      (pend_set_i),
    .irq_req_i       (irq_req_i),
    .pending_o       (pending_o),
    .drv_sem_o       (drv_sem_o),
    .mem_sem_o       (mem_sem_o),
    .init_done_o     (init_done_o),
    .stat3_o         (stat3_o)
  );

  always #20 mclk_i = ~mclk_i;

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0d ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One bus cycle; read data of the previous cycle is compared at this edge
  task automatic op(input logic w, input logic r, input hsp_pkg::hsp_addr_t a,
                    input hsp_pkg::hsp_data_t d, input hsp_pkg::hsp_data_t e);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge mclk_i);
    if (prev_rd) chk(rdata_o, prev_exp);
    prev_rd  = r;
    prev_exp = e;
  endtask

  task automatic idle();
    op(1'b0, 1'b0, 20'h00000, 32'h0000_0000, 32'h0000_0000);
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  initial begin
    repeat (5000) @(posedge mclk_i);
    miscompares++;
    conclude();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    mclk_i = 1'b0;
    rst_n_i = 1'b0;
    bus = '0;
    soft_rst_i = 1'b0;
    pend_clr_deas_i = 1'b1;
    pend_set_i = 5'h00;
    irq_req_i = 5'h00;
    miscompares = 0;
    num_checks = 0;
    prev_rd = 1'b0;
    prev_exp = 32'h0000_0000;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    idle();
    chk(32'({drv_sem_o, mem_sem_o, init_done_o, pending_o}), 32'h0000_0000);
    op(1'b1, 1'b0, `HSP_OFF_CTL2, 32'h0000_0001, 32'h0);
    op(1'b0, 1'b1, `HSP_OFF_SEM, 32'h0, 32'h0000_0000);
    op(1'b0, 1'b1, `HSP_OFF_SEM, 32'h0, 32'h0000_0001);
    op(1'b1, 1'b0, `HSP_OFF_SEM, 32'h0000_0001, 32'h0);
    op(1'b0, 1'b1, `HSP_OFF_SEM, 32'h0, 32'h0000_0001);
    op(1'b1, 1'b0, `HSP_OFF_SEM, 32'h0000_0000, 32'h0);
    op(1'b0, 1'b1, `HSP_OFF_SEM, 32'h0, 32'h0000_0000);
    idle();
    chk(32'(drv_sem_o), 32'h0000_0001);
    op(1'b1, 1'b0, `HSP_OFF_SEM, 32'hFFFF_FFFE, 32'h0);
    op(1'b0, 1'b1, `HSP_OFF_SEM, 32'h0, 32'h0000_0002);
    idle();
    chk(32'(mem_sem_o), 32'h0000_0001);
    // Soft reset beside a write that would keep the memory flag set
    soft_rst_i <= 1'b1;
    op(1'b1, 1'b0, `HSP_OFF_SEM, 32'h0000_0002, 32'h0);
    soft_rst_i <= 1'b0;
    op(1'b0, 1'b1, `HSP_OFF_SEM, 32'h0, 32'h0000_0000);
    idle();
    op(1'b1, 1'b0, `HSP_OFF_CTL2, 32'hFFFF_FFFF, 32'h0);
    op(1'b0, 1'b1, `HSP_OFF_CTL2, 32'h0, 32'h0000_0001);
    op(1'b1, 1'b0, `HSP_OFF_STAT3, 32'hA5A5_5A5A, 32'h0);
    op(1'b0, 1'b1, `HSP_OFF_STAT3, 32'h0, 32'hA5A5_5A5A);
    op(1'b1, 1'b0, 20'h05B54, 32'hFFFF_FFFF, 32'h0);
    op(1'b0, 1'b1, 20'h05B54, 32'h0, 32'h0000_0000);
    idle();
    chk(32'(init_done_o), 32'h0000_0001);
    chk(stat3_o, 32'hA5A5_5A5A);
    pend_set_i <= 5'h1F;
    idle();
    pend_set_i <= 5'h00;
    idle();
    chk(32'(pending_o), 32'h0000_001F);
    op(1'b1, 1'b0, `HSP_OFF_PENDING_ARRAY_CLEAR, 32'hFFFF_FFEA, 32'h0);
    op(1'b0, 1'b1, `HSP_OFF_PENDING_ARRAY_CLEAR, 32'h0, 32'h0000_0000);
    chk(32'(pending_o), 32'h0000_0015);
    // A set in the same cycle as its clear keeps the bit
    pend_set_i <= 5'h02;
    op(1'b1, 1'b0, `HSP_OFF_PENDING_ARRAY_CLEAR, 32'h0000_001F, 32'h0);
    pend_set_i <= 5'h00;
    idle();
    idle();
    chk(32'(pending_o), 32'h0000_0002);
    irq_req_i <= 5'h1F;
    pend_set_i <= 5'h1F;
    idle();
    pend_set_i <= 5'h00;
    idle();
    irq_req_i <= 5'h00;
    idle();
    idle();
    chk(32'(pending_o), 32'h0000_001F);
    pend_clr_deas_i <= 1'b0;
    irq_req_i <= 5'h1F;
    idle();
    irq_req_i <= 5'h1E;
    idle();
    idle();
    chk(32'(pending_o), 32'h0000_001E);
    conclude();
  end
endmodule

`default_nettype wire
